// ---- design/ldl_line_control.sv ----
// Behaviour
// [RQ1] bank zero visible bit shows or blanks panel
// [RQ2] blanked panel drives all columns and rows low
// [RQ3] blanking never alters stored image data
// [RQ4] line ten tall flag written in bank zero
// [RQ5] bank one flags double lines seven to nine
// [RQ6] count low bits bank zero, top bit bank one
// [RQ7] count code k drives 8(k+1) rows
// [RQ8] memory to row mapping ignores line count; in lowest mode the code wraps memory rows at the duty instead
// [RQ9] position field written only in bank one
// [RQ10] centre mode shifts image sixteen rows down
// [RQ11] lowest mode moves first line to bottom
// [RQ12] bottom location follows the programmed duty
// [RQ13] lowest mode plus pinning fixes bottom line
// [RQ14] pinned field holds first one to three lines
// [RQ15] flip input reverses pin to row order
// [RQ16] host writes instructions with select low
`timescale 1ns/1ps
`default_nettype none

module ldl_line_control
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // instruction write port
    input wire logic i_wr_valid,
    input wire logic i_reg_select,
    input wire logic [7:0] i_data,
    input wire logic i_bank_flag,
    // panel wiring options
    input wire logic i_row_order_flip,
    // scan request: physical row pin under query
    input wire logic [6:0] i_pin_index,
    // raw drive levels from the waveform generator
    input wire logic [ldl_pkg::COLUMNS-1:0] i_column_drive,
    input wire logic [ldl_pkg::ROWS-1:0] i_row_drive,
    // programmed state
    output logic o_panel_visible,
    output logic [3:0] o_active_row_count,
    output logic [6:0] o_duty_rows,
    output logic [3:0] o_tall_lines,
    output logic [1:0] o_row_window_shift,
    output logic [1:0] o_pinned_rows,
    // pin mapping answer
    output logic [6:0] o_logical_row,
    output logic o_pin_active,
    output logic o_pin_tall,
    output logic o_pin_pinned,
    // gated panel outputs
    output logic [ldl_pkg::COLUMNS-1:0] o_column_outputs,
    output logic [ldl_pkg::ROWS-1:0] o_row_outputs
);
    // ------------------------------------------------------------
    // control register group
    // ------------------------------------------------------------
    ldl_pkg::ldl_ctl_t ctl_reg;     // programmed instruction state
    ldl_pkg::ldl_ctl_t ctl_next;    // next state from a write
    logic instr_write;              // host instruction write this cycle
    logic [4:0] opcode;             // upper instruction bits

    assign instr_write = i_wr_valid && !i_reg_select; // see [RQ16]
    assign opcode = i_data[7:3];
    // decode a write into whichever field group the bank reaches
    always_comb
    begin
        ctl_next = ctl_reg;
        if (instr_write)
        begin
            case (opcode)
                ldl_pkg::OP_VISIBLE:
                begin
                    if (!i_bank_flag)
                    begin
                        // bank zero: visible bit and line ten
                        ctl_next.visible =
                            i_data[ldl_pkg::BIT_VISIBLE]; // see [RQ1]
                        ctl_next.tall_line_ten =
                            i_data[ldl_pkg::BIT_TALL_TEN]; // see [RQ4]
                    end
                    else
                    begin
                        // bank one: lines nine, eight, seven
                        ctl_next.tall_lines_seven_to_nine =
                            i_data[2:0]; // see [RQ5]
                    end
                end
                ldl_pkg::OP_LINES:
                begin
                    if (!i_bank_flag)
                    begin
                        ctl_next.active_row_count[2:0] =
                            i_data[2:0]; // see [RQ6]
                    end
                    else
                    begin
                        ctl_next.active_row_count[3] =
                            i_data[ldl_pkg::BIT_COUNT_TOP]; // see [RQ6]
                        ctl_next.row_window_shift =
                            i_data[ldl_pkg::BIT_SHIFT_LO +: 2]; // see [RQ9]
                    end
                end
                ldl_pkg::OP_PINNED:
                begin
                    // only the bank one half belongs here
                    if (i_bank_flag)
                    begin
                        ctl_next.pinned_rows = i_data[1:0]; // see [RQ14]
                    end
                end
                default:
                begin
                    // other instructions belong to other blocks
                end
            endcase
        end
    end

    // register the control state
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ctl_reg.visible <= ldl_pkg::VISIBLE_RESET;
            ctl_reg.tall_line_ten <= 1'b0;
            ctl_reg.tall_lines_seven_to_nine <= 3'h0;
            ctl_reg.active_row_count <= ldl_pkg::COUNT_RESET;
            ctl_reg.row_window_shift <= ldl_pkg::SHIFT_NORMAL;
            ctl_reg.pinned_rows <= 2'h0;
        end
        else
        begin
            ctl_reg <= ctl_next;
        end
    end

    // ------------------------------------------------------------
    // duty and pin mapping
    // ------------------------------------------------------------
    logic [3:0] count_clamped;      // codes above nine act as nine
    logic [6:0] duty_rows;          // active row count 8(k+1)
    logic [6:0] pin_flipped;        // pin after optional reversal
    logic [7:0] shifted;            // pin plus window offset
    logic [6:0] logical_row;        // logical row shown on the pin
    logic pin_active;               // pin lies in the driven window

    assign count_clamped = (ctl_reg.active_row_count > ldl_pkg::COUNT_MAX)
        ? ldl_pkg::COUNT_MAX : ctl_reg.active_row_count;
    // 8 x (k+1), kept in seven bits since 80 fits
    assign duty_rows = 7'({count_clamped, 3'h0})
        + ldl_pkg::LINE_ROWS; // see [RQ7]

    // flip first: reversed wiring is normal order read from the far end
    always_comb
    begin
        pin_flipped = i_row_order_flip
            ? (ldl_pkg::LAST_ROW - i_pin_index) : i_pin_index; // see [RQ15]
        shifted = 8'h00;
        logical_row = pin_flipped;
        pin_active = 1'b0;
        case (ctl_reg.row_window_shift)
            ldl_pkg::SHIFT_CENTRE:
            begin
                // pin 17 onward shows row 1; wraps modulo 80
                shifted = {1'b0, pin_flipped} + {1'b0, ldl_pkg::CENTRE_OFFSET};
                logical_row = (shifted > {1'b0, ldl_pkg::LAST_ROW})
                    ? 7'(shifted - 8'h50) : shifted[6:0]; // see [RQ10]
                pin_active = logical_row < duty_rows;
            end
            ldl_pkg::SHIFT_LOWEST:
            begin
                // wrap within the duty so line 1 lands on the last pins
                shifted = {1'b0, pin_flipped} + {1'b0, ldl_pkg::LOWEST_OFFSET};
                logical_row = (shifted >= {1'b0, duty_rows})
                    ? 7'(shifted - {1'b0, duty_rows})
                    : shifted[6:0]; // see [RQ11]
                pin_active = pin_flipped < duty_rows; // see [RQ12]
            end
            default:
            begin
                // normal output, and the reserved code acts as normal
                pin_active = pin_flipped < duty_rows;
            end
        endcase
    end

    // ------------------------------------------------------------
    // per-pin attributes
    // ------------------------------------------------------------
    logic [3:0] line_index;         // zero-based display line
    logic [3:0] tall_lines;         // lines 10..7 tall flags
    logic pin_tall;                 // shown line is doubled
    logic pin_pinned;               // shown line stays during scroll

    assign line_index = 4'(logical_row >> 3);
    assign tall_lines = {ctl_reg.tall_line_ten,
                         ctl_reg.tall_lines_seven_to_nine};

    always_comb
    begin
        pin_tall = 1'b0;
        if (line_index >= 4'h6)
        begin
            pin_tall = tall_lines[2'(line_index - 4'h6)]; // see [RQ4]
        end
        // pinned lines are the first ones: in lowest mode, the bottom one
        pin_pinned = (line_index < {2'h0, ctl_reg.pinned_rows}); // see [RQ13]
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [ldl_pkg::COLUMNS-1:0] col_next;
    logic [ldl_pkg::ROWS-1:0] row_next;

    // blanking only gates drivers; picture memory is never touched
    always_comb
    begin
        col_next = ctl_reg.visible ? i_column_drive : '0; // see [RQ2]
        row_next = ctl_reg.visible ? i_row_drive : '0; // see [RQ3]
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_column_outputs <= '0;
            o_row_outputs <= '0;
            o_logical_row <= 7'h00;
            o_pin_active <= 1'b0;
            o_pin_tall <= 1'b0;
            o_pin_pinned <= 1'b0;
        end
        else
        begin
            o_column_outputs <= col_next;
            o_row_outputs <= row_next;
            // count bounds the window; in lowest mode it also sets where memory rows wrap
            o_logical_row <= logical_row; // see [RQ8]
            o_pin_active <= pin_active;
            o_pin_tall <= pin_tall;
            o_pin_pinned <= pin_pinned;
        end
    end

    assign o_panel_visible = ctl_reg.visible;
    assign o_active_row_count = ctl_reg.active_row_count;
    assign o_duty_rows = duty_rows;
    assign o_tall_lines = tall_lines;
    assign o_row_window_shift = ctl_reg.row_window_shift;
    assign o_pinned_rows = ctl_reg.pinned_rows;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    AST_VISIBLE_WRITE: assert property ( // see [RQ1]
        instr_write && opcode == ldl_pkg::OP_VISIBLE && !i_bank_flag
        |=> o_panel_visible == $past(i_data[2]))
        else $error("visible bit not taken");
    AST_BLANK_LOW: assert property ( // see [RQ2]
        !o_panel_visible |=> o_column_outputs == '0 && o_row_outputs == '0)
        else $error("blanked panel drives outputs");
    AST_SHOW_AGAIN: assert property ( // see [RQ3]
        o_panel_visible |=> o_row_outputs == $past(i_row_drive))
        else $error("visible panel not passing drive");
    AST_TEN_BANK: assert property ( // see [RQ4]
        instr_write && i_bank_flag |=> $stable(o_tall_lines[3]))
        else $error("line ten flag changed from bank one");
    AST_SEVEN_NINE: assert property ( // see [RQ5]
        instr_write && opcode == ldl_pkg::OP_VISIBLE && i_bank_flag
        |=> o_tall_lines[2:0] == $past(i_data[2:0]))
        else $error("tall flags seven to nine not taken");
    AST_COUNT_TOP: assert property ( // see [RQ6]
        instr_write && opcode == ldl_pkg::OP_LINES && !i_bank_flag
        |=> $stable(o_active_row_count[3]))
        else $error("count top bit changed from bank zero");
    AST_DUTY: assert property ( // see [RQ7]
        o_active_row_count == 4'h4 |-> o_duty_rows == 7'h28)
        else $error("duty rows wrong for code four");
    AST_SHIFT_BANK: assert property ( // see [RQ9]
        instr_write && !i_bank_flag |=> $stable(o_row_window_shift))
        else $error("position changed from bank zero");
    AST_CENTRE: assert property ( // see [RQ10]
        o_row_window_shift == ldl_pkg::SHIFT_CENTRE && !i_row_order_flip
        && i_pin_index == 7'h10 ##1 $stable(o_row_window_shift)
        |-> o_logical_row == 7'h00)
        else $error("centre mode does not start at pin seventeen");
    AST_LOWEST: assert property ( // see [RQ11]
        o_row_window_shift == ldl_pkg::SHIFT_LOWEST && !i_row_order_flip
        && i_pin_index == 7'h00 ##1 $stable(o_row_window_shift)
        && $stable(o_duty_rows) && o_duty_rows != 7'h08
        |-> o_logical_row == 7'h08)
        else $error("lowest mode first pin not line two");

endmodule // ldl_line_control
`default_nettype wire

// ---- design/ldl_pkg.sv ----
package ldl_pkg;

    // ------------------------------------------------------------
    // panel geometry
    // ------------------------------------------------------------
    localparam int COLUMNS = 112;                // column output count
    localparam int ROWS = 80;                    // row output count
    localparam logic [6:0] LINE_ROWS = 7'h08;    // raster rows per line
    localparam logic [6:0] LAST_ROW = 7'h4F;     // highest row index

    // ------------------------------------------------------------
    // instruction opcodes, upper five data bits
    // ------------------------------------------------------------
    localparam logic [4:0] OP_VISIBLE = 5'h06;   // visible / tall lines
    localparam logic [4:0] OP_LINES = 5'h07;     // row count / window
    localparam logic [4:0] OP_PINNED = 5'h0A;    // pinned rows (bank 1)

    // ------------------------------------------------------------
    // field positions inside the low data bits
    // ------------------------------------------------------------
    localparam int BIT_VISIBLE = 2;              // bank 0
    localparam int BIT_TALL_TEN = 1;             // bank 0
    localparam int BIT_COUNT_TOP = 0;            // bank 1
    localparam int BIT_SHIFT_LO = 1;             // bank 1, two bits

    // ------------------------------------------------------------
    // window shift codes and row offsets
    // ------------------------------------------------------------
    localparam logic [1:0] SHIFT_NORMAL = 2'h0;
    localparam logic [1:0] SHIFT_CENTRE = 2'h1;
    localparam logic [1:0] SHIFT_LOWEST = 2'h2;
    localparam logic [6:0] CENTRE_OFFSET = 7'h40; // pin 17 shows row 1
    localparam logic [6:0] LOWEST_OFFSET = 7'h08; // line 1 goes to bottom

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [3:0] COUNT_MAX = 4'h9;     // highest legal count
    localparam logic [3:0] COUNT_RESET = 4'h9;   // full 80-row duty
    localparam logic VISIBLE_RESET = 1'b0;       // panel blank from reset

    // ------------------------------------------------------------
    // programmed control state
    // ------------------------------------------------------------
    typedef struct packed {
        logic visible;                           // panel image enabled
        logic tall_line_ten;                     // line 10 doubled
        logic [2:0] tall_lines_seven_to_nine;    // lines 9..7 doubled
        logic [3:0] active_row_count;            // line count code
        logic [1:0] row_window_shift;            // output position
        logic [1:0] pinned_rows;                 // lines held still
    } ldl_ctl_t;

endpackage

// ---- verif/ldl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// host side of the instruction port
// --------------------------------------------------------------
module ldl_host_model
(
    // clock
    input wire logic i_clock,
    // instruction bus toward the device
    output logic o_wr_valid,
    output logic o_reg_select,
    output logic [7:0] o_data,
    output logic o_bank_flag
);
    // idle: strobe low, select parked high so nothing is taken
    initial
    begin
        o_wr_valid = 1'b0;
        o_reg_select = 1'b1;
        o_data = 8'h00;
        o_bank_flag = 1'b0;
    end

    // one write, launched after an edge and held over the taking edge
    task automatic send(input logic [7:0] val, input logic bank,
                        input logic sel);
        @(posedge i_clock);
        o_wr_valid <= 1'b1;
        o_reg_select <= sel;
        o_data <= val;
        o_bank_flag <= bank;
        @(posedge i_clock);
        // released lines show the inverse so stale values never match
        o_wr_valid <= 1'b0;
        o_reg_select <= 1'b1;
        o_data <= ~val;
        o_bank_flag <= ~bank;
    endtask
endmodule // ldl_host_model

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    // --------------------------------------------------------------
    // stimulus and observed signals
    // --------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic flip = 1'b0;                       // row order wiring option
    logic [6:0] pin = 7'h00;                 // queried row pin
    logic [111:0] col_drv = {14{8'hA5}};     // raw column levels
    logic [79:0] row_drv = {10{8'h3C}};      // raw row levels
    logic wr_valid, reg_sel, bank;
    logic [7:0] data;
    logic vis, p_act, p_tall, p_pin;
    logic [3:0] cnt, tall, prev_cnt;
    logic [6:0] duty, lrow;
    logic [1:0] shift, pinned, prev_shift;
    logic [111:0] col_out;
    logic [79:0] row_out;
    logic [3:0] tall_exp = 4'hD;             // flags left after tall tests
    int error_cnt = 0;
    int samples_checked = 0;

    always #12.5 i_clock = ~i_clock;

    ldl_host_model ldl_host_model_i (.i_clock(i_clock),
        .o_wr_valid(wr_valid), .o_reg_select(reg_sel), .o_data(data),
        .o_bank_flag(bank));

    ldl_line_control ldl_line_control_i (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_wr_valid(wr_valid), .i_reg_select(reg_sel),
        .i_data(data), .i_bank_flag(bank), .i_row_order_flip(flip),
        .i_pin_index(pin), .i_column_drive(col_drv), .i_row_drive(row_drv),
        .o_panel_visible(vis), .o_active_row_count(cnt), .o_duty_rows(duty),
        .o_tall_lines(tall), .o_row_window_shift(shift),
        .o_pinned_rows(pinned), .o_logical_row(lrow), .o_pin_active(p_act),
        .o_pin_tall(p_tall), .o_pin_pinned(p_pin),
        .o_column_outputs(col_out), .o_row_outputs(row_out));

    // --------------------------------------------------------------
    // compare, access and report tasks
    // --------------------------------------------------------------
    task automatic cmp_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bus(input string what, input logic [111:0] exp,
                           input logic [111:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // instruction write; registers have settled when it returns
    task automatic wr(input logic [7:0] val, input logic bk);
        ldl_host_model_i.send(val, bk, 1'b0);
        #1;
    endtask

    // line count code k in two halves, setting window shift sh
    task automatic set_count(input logic [3:0] k, input logic [1:0] sh);
        prev_cnt = cnt;
        prev_shift = shift;
        wr({ldl_pkg::OP_LINES, k[2:0]}, 1'b0);
        cmp_val("count low half", {prev_cnt[3], k[2:0]}, cnt);
        cmp_val("shift kept", prev_shift, shift);
        wr({ldl_pkg::OP_LINES, sh, k[3]}, 1'b1);
        cmp_val("count", k, cnt);
    endtask

    // query one pin and compare the mapping answer with our own model
    task automatic probe(input int p, input int sh, input int fl,
                         input int k, input int pn);
        int q;
        int de;
        int row;
        logic act;
        logic tex;
        q = fl ? 79 - p : p;
        de = 8 * ((k > 9 ? 9 : k) + 1);
        row = (sh == 1) ? (q + 64) % 80 : q;
        // lowest mode folds once at the duty; undriven pins fold too
        if (sh == 2)
            row = (q + 8 >= de) ? q + 8 - de : q + 8;
        act = (sh == 1) ? (row < de) : (q < de);
        @(posedge i_clock);
        pin <= p[6:0];
        flip <= fl[0];
        @(posedge i_clock);
        #1;
        cmp_val("row", row[6:0], lrow);
        cmp_val("pin active", act, p_act);
        if (act)
        begin
            // tall and pinned follow the line that the pin shows
            tex = (row / 8 >= 6) ? tall_exp[row / 8 - 6] : 1'b0;
            cmp_val("pin tall", tex, p_tall);
            cmp_val("pin pinned", row / 8 < pn, p_pin);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        #1;
        cmp_val("visible", 16'h0000, vis);
        cmp_val("duty", 16'h0050, duty);
        cmp_bus("columns", '0, col_out);
        // panel shows drive levels once visible, blank otherwise
        wr({ldl_pkg::OP_VISIBLE, 3'h4}, 1'b0);
        cmp_val("visible", 16'h0001, vis);
        @(posedge i_clock);
        col_drv <= ~col_drv;
        row_drv <= ~row_drv;
        @(posedge i_clock);
        #1;
        cmp_bus("columns", col_drv, col_out);
        cmp_bus("rows", {32'h0, row_drv}, {32'h0, row_out});
        wr({ldl_pkg::OP_VISIBLE, 3'h0}, 1'b0);
        @(posedge i_clock);
        #1;
        cmp_bus("columns", '0, col_out);
        cmp_bus("rows", '0, {32'h0, row_out});
        // select high: not an instruction, must be ignored
        ldl_host_model_i.send({ldl_pkg::OP_VISIBLE, 3'h4}, 1'b0, 1'b1);
        #1;
        cmp_val("visible", 16'h0000, vis);
        wr({ldl_pkg::OP_VISIBLE, 3'h6}, 1'b0);
        // gated outputs follow the visible bit one edge later
        @(posedge i_clock);
        #1;
        cmp_bus("columns", col_drv, col_out);
        cmp_val("tall", 16'h0008, tall);
        for (int i = 0; i < 3; i++)
        begin
            wr({ldl_pkg::OP_VISIBLE, 3'h1 << i}, 1'b1);
            cmp_val("tall", {1'b1, 3'h1 << i}, tall);
        end
        wr({ldl_pkg::OP_VISIBLE, 3'h5}, 1'b1);
        cmp_val("tall", tall_exp, tall);
        // every count code, plus one above the legal range
        for (int k = 0; k < 11; k++)
        begin
            set_count(k[3:0], 2'h1);
            cmp_val("duty", 8 * ((k > 9 ? 9 : k) + 1), duty);
        end
        wr({ldl_pkg::OP_PINNED, 3'h3}, 1'b0);
        cmp_val("pinned", 16'h0000, pinned);
        // mapping over all window modes, both orders, two duties
        for (int sh = 0; sh < 3; sh++)
            for (int fl = 0; fl < 2; fl++)
                for (int c = 0; c < 2; c++)
                begin
                    set_count(c ? 4'h3 : 4'h9, sh[1:0]);
                    cmp_val("shift", sh, shift);
                    wr({ldl_pkg::OP_PINNED, 1'b0, 2'(sh + 1)}, 1'b1);
                    cmp_val("pinned", sh + 1, pinned);
                    for (int p = 0; p < 80; p += 3)
                        probe(p, sh, fl, c ? 3 : 9, sh + 1);
                end
        give_verdict();
    end

    // a hung run ends here as a mismatch
    initial
    begin
        repeat (20000) @(posedge i_clock);
        $display("Error run exceeded its cycle limit");
        error_cnt++;
        give_verdict();
    end
endmodule // tb

`default_nettype wire
